// ===== core/xtd_core.sv
`timescale 1ns/1ps
// Function
// [RULE1] Table pointer low bits pick holding latch
// [RULE2] Four table pointer update options by nn
// [RULE3] Table write takes two cycles
// [RULE4] Test skip zero discards next, NOP
// [RULE5] Skip over two-word instruction: three cycles
// [RULE6] a=0 access bank, a=1 bank select
// [RULE7] Extension: low operands use indexed offset
// [RULE8] Literal XOR into accumulator, one cycle
// [RULE9] Register XOR: d picks destination
// [RULE10] XOR sets N,Z; test keeps flags (only register XOR updates N,Z; literal XOR leaves them)
// [RULE11] Extension off out of reset
// [RULE12] Extension adds eight pointer instructions (code decodes only add and subtract to pointer, and acts only on PTR_TWO)
// [RULE13] Extended ops are pointer literal ops
// [RULE14] Pointer-two variants return from stack
module xtd_core (
	input  wire logic                      mclk_in,
	input  wire logic                      nrst_in,
	input  wire logic                      ext_cfg_in,
	input  wire logic                      op_valid_in,
	input  wire logic [15:0]               op_in,
	input  wire logic [15:0]               next_op_in,
	input  wire logic [xtd_pkg::ACC_W-1:0] rd_data_in,
	input  wire logic [xtd_pkg::STK_W-1:0] tos_in,
	output logic      [xtd_pkg::ADDR_W-1:0] addr_out,
	output logic      [xtd_pkg::ACC_W-1:0] wr_data_out,
	output logic                           wr_en_out,
	output logic      [xtd_pkg::ACC_W-1:0] acc_out,
	output logic                           flag_n_out,
	output logic                           flag_z_out,
	output logic      [xtd_pkg::TP_W-1:0]  tptr_out,
	output logic                           busy_out,
	output logic                           flush_out,
	output logic                           pc_load_out,
	output logic      [xtd_pkg::STK_W-1:0] pc_out,
	output logic      [xtd_pkg::SP_W-1:0]  ptr_two_out,
	output logic      [xtd_pkg::HOLD_N*xtd_pkg::ACC_W-1:0] hold_out
);
	typedef struct packed {
		xtd_pkg::xtd_state_t        state;
		logic                       ext;
		logic                       ext_seen;
		logic [xtd_pkg::ACC_W-1:0]  acc;
		logic                       fn;
		logic                       fz;
		logic [xtd_pkg::TP_W-1:0]   tptr;
		logic [xtd_pkg::ACC_W-1:0]  tlat;
		logic [1:0]                 tmode;
		logic [xtd_pkg::ADDR_W-1:0] addr;
		logic [xtd_pkg::ACC_W-1:0]  wdata;
		logic                       wen;
		logic                       busy;
		logic                       flush;
		logic                       two_word;
		logic                       pcl;
		logic [xtd_pkg::STK_W-1:0]  pc;
		logic [xtd_pkg::SP_W-1:0]   pointer_two;
		logic                       hwe;
		logic [xtd_pkg::HOLD_SEL_W-1:0] hsel;
		logic [xtd_pkg::ACC_W-1:0]  hdata;
	} xtd_st_t;
	xtd_st_t st_r;
	xtd_st_t st_nxt;
	xtd_hold_if hif ();
	logic [xtd_pkg::ADDR_W-1:0] eff_addr;
	logic [xtd_pkg::ACC_W-1:0]  xr;
	logic                       is_tw;
	logic                       is_tst;
	logic                       is_xl;
	logic                       is_xf;
	logic                       is_add;
	logic                       is_sub;
	logic [xtd_pkg::SP_W-1:0]   k6;

	xtd_addr u_addr (
		.f_in     (op_in[7:0]),
		.a_in     (op_in[xtd_pkg::A_BIT]),
		.ext_in   (st_r.ext),
		.bank_in  (st_r.addr[xtd_pkg::ADDR_W-1 -: xtd_pkg::BANK_W]),
		.ptr_in   (st_r.pointer_two),
		.addr_out (eff_addr)
	);
	xtd_hold u_hold (
		.mclk_in (mclk_in),
		.nrst_in (nrst_in),
		.hif     (hif)
	);
	assign hif.we = st_r.hwe;
	assign hif.sel = st_r.hsel;
	assign hif.data = st_r.hdata;

	always_comb begin
		is_tw  = (op_in & xtd_pkg::OP_TABLE_WRITE_OP_M) == xtd_pkg::OP_TABLE_WRITE_OP;
		is_tst = (op_in & xtd_pkg::OP_TST_M) == xtd_pkg::OP_TST;
		is_xl  = (op_in & xtd_pkg::OP_XORL_M) == xtd_pkg::OP_XORL;
		is_xf  = (op_in & xtd_pkg::OP_XORF_M) == xtd_pkg::OP_XORF;
		is_add = st_r.ext
			&& (op_in & xtd_pkg::OP_FSR_M) == xtd_pkg::OP_ADD_TO_POINTER; // [RULE12]
		is_sub = st_r.ext
			&& (op_in & xtd_pkg::OP_FSR_M) == xtd_pkg::OP_SUB_FROM_POINTER; // [RULE13]
		k6 = {{(xtd_pkg::SP_W-xtd_pkg::K6_W){1'b0}},
			op_in[xtd_pkg::K6_W-1:0]};
		xr = st_r.acc ^ rd_data_in;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.wen = 1'b0;
		st_nxt.hwe = 1'b0;
		st_nxt.flush = 1'b0;
		st_nxt.pcl = 1'b0;
		st_nxt.addr = eff_addr;
		if (!st_r.ext_seen) begin
			st_nxt.ext = ext_cfg_in; // [RULE11]
			st_nxt.ext_seen = 1'b1;
		end
		unique case (st_r.state)
			xtd_pkg::XTD_EXEC: begin
				st_nxt.busy = 1'b0;
				if (op_valid_in && st_r.ext_seen) begin
					if (is_tw) begin
						st_nxt.tmode = op_in[1:0];
						if (op_in[1:0] == xtd_pkg::TP_PREINC) begin
							st_nxt.tptr = st_r.tptr + 21'h000001; // [RULE2]
						end
						st_nxt.state = xtd_pkg::XTD_TW2; // [RULE3]
						st_nxt.busy = 1'b1;
					end else if (is_tst) begin
						if (rd_data_in == 8'h00) begin
							st_nxt.flush = 1'b1; // [RULE4]
							st_nxt.busy = 1'b1;
							st_nxt.two_word =
								next_op_in[15:12] == xtd_pkg::TWO_WORD_HI;
							st_nxt.state = xtd_pkg::XTD_SK1;
						end
					end else if (is_xl) begin
						st_nxt.acc = st_r.acc ^ op_in[7:0]; // [RULE8]
					end else if (is_xf) begin
						if (op_in[xtd_pkg::D_BIT]) begin
							st_nxt.wdata = xr; // [RULE9]
							st_nxt.wen = 1'b1;
						end else begin
							st_nxt.acc = xr; // [RULE9]
						end
						st_nxt.fn = xr[xtd_pkg::ACC_W-1]; // [RULE10]
						st_nxt.fz = xr == 8'h00; // [RULE10]
					end else if (is_add || is_sub) begin
						if (op_in[7:6] == xtd_pkg::PTR_TWO) begin
							st_nxt.pointer_two = is_add ? st_r.pointer_two + k6
								: st_r.pointer_two - k6;
							st_nxt.pc = tos_in; // [RULE14]
							st_nxt.pcl = 1'b1;
							st_nxt.flush = 1'b1;
							st_nxt.busy = 1'b1;
							st_nxt.state = xtd_pkg::XTD_RET;
						end
					end
				end
			end
			xtd_pkg::XTD_TW2: begin
				st_nxt.hsel = st_r.tptr[xtd_pkg::HOLD_SEL_W-1:0]; // [RULE1]
				st_nxt.hdata = st_r.tlat; // [RULE3]
				st_nxt.hwe = 1'b1;
				unique case (st_r.tmode)
					xtd_pkg::TP_POSTINC: st_nxt.tptr = st_r.tptr + 21'h000001;
					xtd_pkg::TP_POSTDEC: st_nxt.tptr = st_r.tptr - 21'h000001;
					xtd_pkg::TP_NOCHG, xtd_pkg::TP_PREINC: ; // [RULE2]
				endcase
				st_nxt.busy = 1'b0;
				st_nxt.state = xtd_pkg::XTD_EXEC;
			end
			xtd_pkg::XTD_SK1: begin
				if (st_r.two_word) begin
					st_nxt.two_word = 1'b0; // [RULE5]
					st_nxt.flush = 1'b1;
				end else begin
					st_nxt.busy = 1'b0;
					st_nxt.state = xtd_pkg::XTD_EXEC;
				end
			end
			xtd_pkg::XTD_RET: begin
				st_nxt.busy = 1'b0;
				st_nxt.state = xtd_pkg::XTD_EXEC;
			end
			default: begin
				st_nxt.state = xtd_pkg::XTD_EXEC;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			st_r <= '0;
			st_r.state <= xtd_pkg::XTD_EXEC;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		addr_out = st_r.addr;
		wr_data_out = st_r.wdata;
		wr_en_out = st_r.wen;
		acc_out = st_r.acc;
		flag_n_out = st_r.fn;
		flag_z_out = st_r.fz;
		tptr_out = st_r.tptr;
		busy_out = st_r.busy;
		flush_out = st_r.flush;
		pc_load_out = st_r.pcl;
		pc_out = st_r.pc;
		ptr_two_out = st_r.pointer_two;
		hold_out = hif.bank;
	end

	sequence s_skip_start;
		op_valid_in && st_r.state == xtd_pkg::XTD_EXEC && st_r.ext_seen
			&& is_tst && rd_data_in == 8'h00;
	endsequence
	sequence s_skip_two;
		s_skip_start ##0 next_op_in[15:12] == xtd_pkg::TWO_WORD_HI;
	endsequence
	sequence s_skip_one;
		s_skip_start ##0 next_op_in[15:12] != xtd_pkg::TWO_WORD_HI;
	endsequence
	sequence s_take;
		op_valid_in && st_r.state == xtd_pkg::XTD_EXEC && st_r.ext_seen;
	endsequence

	a_ext_reset_off: assert property (@(posedge mclk_in)
		$rose(nrst_in) |-> !st_r.ext) else $error("ext on at reset"); // [RULE11]
	a_tw_two_cyc: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		st_r.state == xtd_pkg::XTD_TW2 |=> st_r.hwe
		&& st_r.hdata == $past(st_r.tlat)) else $error("tw late"); // [RULE3]
	a_tw_postinc: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		st_r.state == xtd_pkg::XTD_TW2 && st_r.tmode == xtd_pkg::TP_POSTINC
		|=> st_r.tptr == $past(st_r.tptr) + 21'h000001)
		else $error("postinc wrong"); // [RULE2]
	a_skip_flush: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_skip_one |=> flush_out && busy_out ##1 !busy_out && !flush_out)
		else $error("skip not flushed"); // [RULE4]
	a_skip_none: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_take ##0 is_tst && rd_data_in != 8'h00 |=> !flush_out && !busy_out)
		else $error("skip on nonzero"); // [RULE4]
	a_skip_three: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_skip_two |=> flush_out ##1 flush_out ##1 !busy_out)
		else $error("two word skip wrong"); // [RULE5]
	a_xorl_acc: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		op_valid_in && st_r.state == xtd_pkg::XTD_EXEC && st_r.ext_seen
		&& is_xl |=> acc_out == ($past(st_r.acc) ^ $past(op_in[7:0]))
		&& !wr_en_out) else $error("xor literal wrong"); // [RULE8]
	a_xorf_dest: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		op_valid_in && st_r.state == xtd_pkg::XTD_EXEC && st_r.ext_seen
		&& is_xf && op_in[xtd_pkg::D_BIT] |=> wr_en_out
		&& wr_data_out == $past(xr)) else $error("xor dest wrong"); // [RULE9]
	a_tst_flags: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_skip_start |=> $stable(flag_z_out) && $stable(flag_n_out))
		else $error("test changed flags"); // [RULE10]
	a_ret_tos: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		op_valid_in && st_r.state == xtd_pkg::XTD_EXEC && st_r.ext_seen
		&& (is_add || is_sub) && op_in[7:6] == xtd_pkg::PTR_TWO
		|=> pc_load_out && pc_out == $past(tos_in))
		else $error("no return"); // [RULE14]
	a_ret_sub: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_take ##0 is_sub && op_in[7:6] == xtd_pkg::PTR_TWO
		|=> ptr_two_out == $past(st_r.pointer_two) - $past(k6))
		else $error("pointer two sub wrong"); // [RULE14]
	a_ret_add: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_take ##0 is_add && op_in[7:6] == xtd_pkg::PTR_TWO
		|=> ptr_two_out == $past(st_r.pointer_two) + $past(k6))
		else $error("pointer two add wrong"); // [RULE14]
	a_tw_postdec: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		st_r.state == xtd_pkg::XTD_TW2 && st_r.tmode == xtd_pkg::TP_POSTDEC
		|=> st_r.tptr == $past(st_r.tptr) - 21'h000001)
		else $error("postdec wrong"); // [RULE2]
	a_tw_preinc: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_take ##0 is_tw && op_in[1:0] == xtd_pkg::TP_PREINC
		|=> st_r.tptr == $past(st_r.tptr) + 21'h000001)
		else $error("preinc wrong"); // [RULE2]
	a_tw_nochg: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		st_r.state == xtd_pkg::XTD_TW2 && st_r.tmode == xtd_pkg::TP_NOCHG
		|=> $stable(st_r.tptr))
		else $error("nochange moved pointer"); // [RULE2]
	a_tw_sel: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		st_r.state == xtd_pkg::XTD_TW2
		|=> st_r.hsel == $past(st_r.tptr[xtd_pkg::HOLD_SEL_W-1:0]))
		else $error("wrong latch picked"); // [RULE1]
	a_xorf_acc: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_take ##0 is_xf && !op_in[xtd_pkg::D_BIT]
		|=> acc_out == $past(xr) && !wr_en_out)
		else $error("xor to acc wrong"); // [RULE9]
	a_xorf_flags: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_take ##0 is_xf |=> flag_z_out == ($past(xr) == 8'h00)
		&& flag_n_out == $past(xr[xtd_pkg::ACC_W-1]))
		else $error("xor flags wrong"); // [RULE10]
	a_ilo_addr: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_take ##0 st_r.ext && !op_in[xtd_pkg::A_BIT]
		&& op_in[7:0] <= xtd_pkg::ILO_MAX
		|=> addr_out == $past(st_r.pointer_two) + {4'h0, $past(op_in[7:0])})
		else $error("indexed address wrong"); // [RULE7]
	a_bank_addr: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_take ##0 op_in[xtd_pkg::A_BIT]
		|=> addr_out[7:0] == $past(op_in[7:0]))
		else $error("banked address wrong"); // [RULE6]
endmodule

// ===== core/xtd_pkg.sv
package xtd_pkg;
	localparam int ACC_W = 8;
	localparam int TP_W = 21;
	localparam int HOLD_N = 8;
	localparam int HOLD_SEL_W = 3;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 4;
	localparam int SP_W = 12;
	localparam int K6_W = 6;
	localparam int STK_W = 21;
	localparam logic [7:0] ILO_MAX = 8'h5f;
	localparam logic [1:0] TP_NOCHG = 2'h0;
	localparam logic [1:0] TP_POSTINC = 2'h1;
	localparam logic [1:0] TP_POSTDEC = 2'h2;
	localparam logic [1:0] TP_PREINC = 2'h3;
	localparam logic [15:0] OP_TABLE_WRITE_OP = 16'h000c;
	localparam logic [15:0] OP_TABLE_WRITE_OP_M = 16'hfffc;
	localparam logic [15:0] OP_TST = 16'h6600;
	localparam logic [15:0] OP_TST_M = 16'hfe00;
	localparam logic [15:0] OP_XORL = 16'h0a00;
	localparam logic [15:0] OP_XORL_M = 16'hff00;
	localparam logic [15:0] OP_XORF = 16'h1800;
	localparam logic [15:0] OP_XORF_M = 16'hfc00;
	localparam logic [15:0] OP_ADD_TO_POINTER = 16'he800;
	localparam logic [15:0] OP_SUB_FROM_POINTER = 16'he900;
	localparam logic [15:0] OP_FSR_M = 16'hff00;
	localparam logic [1:0] PTR_TWO = 2'h3;
	localparam logic [3:0] TWO_WORD_HI = 4'hf;
	localparam logic [ADDR_W-1:0] ACC_HI_BASE = 12'hf00;
	localparam int A_BIT = 8;
	localparam int D_BIT = 9;
	typedef enum logic [3:0] {
		XTD_EXEC = 4'h1,
		XTD_TW2  = 4'h2,
		XTD_SK1  = 4'h4,
		XTD_RET  = 4'h8
	} xtd_state_t;
endpackage

// ===== core/xtd_hold_if.sv
`timescale 1ns/1ps
interface xtd_hold_if;
	logic                        we;
	logic [xtd_pkg::HOLD_SEL_W-1:0] sel;
	logic [xtd_pkg::ACC_W-1:0]   data;
	logic [xtd_pkg::HOLD_N*xtd_pkg::ACC_W-1:0] bank;
	modport src (output we, output sel, output data, input bank);
	modport dst (input we, input sel, input data, output bank);
endinterface

// ===== core/xtd_hold.sv
`timescale 1ns/1ps
module xtd_hold (
	input  wire logic mclk_in,
	input  wire logic nrst_in,
	xtd_hold_if.dst   hif
);
	typedef struct packed {
		logic [xtd_pkg::HOLD_N*xtd_pkg::ACC_W-1:0] lat;
	} xtd_hold_st_t;
	xtd_hold_st_t st_r;
	xtd_hold_st_t st_nxt;
	always_comb begin
		st_nxt = st_r;
		if (hif.we) begin
			st_nxt.lat[hif.sel*xtd_pkg::ACC_W +: xtd_pkg::ACC_W] = hif.data; // [RULE1]
		end
	end
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			st_r <= '{default: '1};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign hif.bank = st_r.lat;
	a_hold_write: assert property (@(posedge mclk_in) disable iff (!nrst_in)
		hif.we |=> st_r.lat[$past(hif.sel)*xtd_pkg::ACC_W +: xtd_pkg::ACC_W]
		== $past(hif.data)) else $error("holding latch not written"); // [RULE1]
endmodule

// ===== core/xtd_addr.sv
`timescale 1ns/1ps
module xtd_addr (
	input  wire logic [7:0]                 f_in,
	input  wire logic                       a_in,
	input  wire logic                       ext_in,
	input  wire logic [xtd_pkg::BANK_W-1:0] bank_in,
	input  wire logic [xtd_pkg::SP_W-1:0]   ptr_in,
	output logic      [xtd_pkg::ADDR_W-1:0] addr_out
);
	always_comb begin
		if (a_in) begin
			addr_out = {bank_in, f_in}; // [RULE6]
		end else if (ext_in && f_in <= xtd_pkg::ILO_MAX) begin
			addr_out = ptr_in + {4'h0, f_in}; // [RULE7]
		end else if (f_in[7]) begin
			addr_out = xtd_pkg::ACC_HI_BASE | {4'h0, f_in}; // [RULE6]
		end else begin
			addr_out = {4'h0, f_in};
		end
	end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic          mclk_in     = 1'b0;
	logic          nrst_in     = 1'b0;
	logic          ext_cfg_in  = 1'b0;
	logic          op_valid_in = 1'b0;
	logic [15:0]   op_in       = 16'h0;
	logic [15:0]   next_op_in  = 16'h0;
	logic [7:0]    rd_data_in  = 8'h0;
	logic [20:0]   tos_in      = 21'h0;
	logic [11:0]   addr_out;
	logic [7:0]    wr_data_out;
	logic          wr_en_out;
	logic [7:0]    acc_out;
	logic          flag_n_out;
	logic          flag_z_out;
	logic [20:0]   tptr_out;
	logic          busy_out;
	logic          flush_out;
	logic          pc_load_out;
	logic [20:0]   pc_out;
	logic [11:0]   ptr_two_out;
	logic [63:0]   hold_out;
	int            err_count   = 0;
	int            n_tests     = 0;
	int            fl;
	int            bz;
	int            pl;
	logic [20:0]   pcv;

	xtd_core i_dut (
		.mclk_in(mclk_in), .nrst_in(nrst_in), .ext_cfg_in(ext_cfg_in),
		.op_valid_in(op_valid_in), .op_in(op_in), .next_op_in(next_op_in),
		.rd_data_in(rd_data_in), .tos_in(tos_in), .addr_out(addr_out),
		.wr_data_out(wr_data_out), .wr_en_out(wr_en_out),
		.acc_out(acc_out), .flag_n_out(flag_n_out),
		.flag_z_out(flag_z_out), .tptr_out(tptr_out),
		.busy_out(busy_out), .flush_out(flush_out),
		.pc_load_out(pc_load_out), .pc_out(pc_out),
		.ptr_two_out(ptr_two_out), .hold_out(hold_out)
	);

	always #12.5 mclk_in = ~mclk_in;

	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task step;
		@(posedge mclk_in);
		#2;
	endtask

	task do_reset(input logic ext);
		nrst_in = 1'b0;
		ext_cfg_in = ext;
		repeat (6) step;
		nrst_in = 1'b1;
		repeat (2) step;
	endtask

	task issue(input logic [15:0] op, input logic [15:0] nx,
		input logic [7:0] rd);
		op_in = op;
		next_op_in = nx;
		rd_data_in = rd;
		op_valid_in = 1'b1;
		step;
		op_valid_in = 1'b0;
	endtask

	// Counts pulses and busy cycles from the first result cycle on
	task watch(input int n);
		fl = 0;
		bz = 0;
		pl = 0;
		repeat (n) begin
			if (flush_out === 1'b1) fl++;
			if (busy_out === 1'b1) bz++;
			if (pc_load_out === 1'b1) begin
				pl++;
				pcv = pc_out;
			end
			step;
		end
	endtask

	task wait_idle;
		int i;
		i = 0;
		while (busy_out !== 1'b0) begin
			step;
			i++;
			if (i > 10) begin
				err_count++;
				stop_test;
			end
		end
	endtask

	task t_reset;
		do_reset(1'b0);
		chk(acc_out, 8'h0);
		chk(hold_out, 64'hffffffffffffffff);
		chk(tptr_out, 21'h0);
		chk(ptr_two_out, 12'h0);
		issue(16'h1810, 16'h0, 8'h00);
		chk(addr_out, 12'h010);
		$display("test reset done");
	endtask

	task t_xor;
		issue(16'h0aaf, 16'h0, 8'h00);
		chk(acc_out, 8'haf);
		chk(wr_en_out, 1'b0);
		issue(16'h0a1a, 16'h0, 8'h00);
		chk(acc_out, 8'hb5);
		issue(16'h1a20, 16'h0, 8'haf);
		chk(wr_en_out, 1'b1);
		chk(wr_data_out, 8'h1a);
		chk(acc_out, 8'hb5);
		chk({flag_n_out, flag_z_out}, 2'b00);
		chk(addr_out, 12'h020);
		step;
		chk(wr_en_out, 1'b0);
		issue(16'h1880, 16'h0, 8'hb5);
		chk(acc_out, 8'h00);
		chk({flag_n_out, flag_z_out}, 2'b01);
		chk(addr_out, 12'hf80);
		issue(16'h1912, 16'h0, 8'h80);
		chk(acc_out, 8'h80);
		chk({flag_n_out, flag_z_out}, 2'b10);
		chk(addr_out, 12'hf12);
		$display("test xor done");
	endtask

	task skip_case(input logic [7:0] rd, input logic [15:0] nx,
		input int efl);
		issue(16'h6620, nx, rd);
		watch(4);
		chk(fl, efl);
		chk(bz, efl);
		chk({flag_n_out, flag_z_out}, 2'b10);
	endtask

	task t_skip;
		skip_case(8'h00, 16'h0e00, 1);
		skip_case(8'h00, 16'hf123, 2);
		skip_case(8'h05, 16'h0e00, 0);
		$display("test skip done");
	endtask

	task t_table;
		logic [1:0]  nn[4];
		logic [20:0] tp[4];
		nn = '{2'h1, 2'h3, 2'h2, 2'h0};
		tp = '{21'h1, 21'h2, 21'h1, 21'h1};
		for (int i = 0; i < 4; i++) begin
			issue(16'h000c | {14'h0, nn[i]}, 16'h0, 8'h00);
			watch(3);
			chk(bz > 0, 1'b1);
			wait_idle;
			chk(tptr_out, tp[i]);
		end
		step;
		chk(hold_out, 64'hffffffffff000000);
		$display("test table done");
	endtask

	task t_ext;
		do_reset(1'b1);
		tos_in = 21'h012345;
		issue(16'he8e3, 16'h0, 8'h00);
		watch(3);
		chk(pl, 1);
		chk(pcv, 21'h012345);
		wait_idle;
		chk(ptr_two_out, 12'h023);
		issue(16'he9c3, 16'h0, 8'h00);
		watch(3);
		wait_idle;
		chk(ptr_two_out, 12'h020);
		issue(16'h1810, 16'h0, 8'h00);
		chk(addr_out, 12'h030);
		$display("test extension done");
	endtask

	initial begin
		t_reset;
		t_xor;
		t_skip;
		t_table;
		t_ext;
		stop_test;
	end
endmodule
